// >>> hdl/swat_pkg.sv
// Timing constants and line states for the single-wire activation logic
// Assumes a 25 MHz reference clock; counts are derived from it
package swat_pkg;

  // ==========================================================
  // Reference clock
  localparam int unsigned CLK_KHZ = 25000;

  // ==========================================================
  // Times as specified
  localparam int unsigned LINE_RAISE_COLD_US = 1000;
  localparam int unsigned WARM_RESUME_US = 500;
  localparam int unsigned RESYNC_WINDOW_US = 2000;
  localparam int unsigned ABANDON_MS = 100;
  localparam int unsigned GND_CLAMP_S = 2;
  localparam int unsigned DEACT_LOW_US = 100;

  // ==========================================================
  // Cycle counts (longest times, rounded down)
  localparam int unsigned WARM_RESUME_CYC = WARM_RESUME_US * CLK_KHZ / 1000;
  localparam int unsigned RESYNC_WINDOW_CYC = RESYNC_WINDOW_US * CLK_KHZ / 1000;
  localparam int unsigned ABANDON_CYC = ABANDON_MS * CLK_KHZ;
  localparam int unsigned GND_CLAMP_CYC = GND_CLAMP_S * CLK_KHZ * 1000;
  localparam int unsigned DEACT_LOW_CYC = DEACT_LOW_US * CLK_KHZ / 1000;

  // ==========================================================
  // Counter width and line states
  localparam int unsigned CNT_W = 32;
  typedef logic [CNT_W-1:0] swat_cnt_t;

  typedef enum logic [2:0] {
    ST_DEACT,
    ST_SUSP,
    ST_PEND,
    ST_RESUME,
    ST_ACTIVE,
    ST_INHIBIT
  } swat_state_e;

endpackage

// >>> hdl/swat_top.sv
// Card-side activation timing for the single-wire link
// Assumes frame layer logic on the same clock; line pins are asynchronous
//
// Overview of operation
// - Resume for resent sync frame starts within 2000 us of power frame end.
// - Unanswered resume is abandoned within 100 ms; block then stays inhibited until line deactivation.
// - From deactivated, card resumes within 500 us after the line goes high.
// - Contact not tied to supply, no terminal support: ground it within 2 s.
// - Slave current means something only while master voltage is high.
// - Link activation after contact activation counts as application selection.
// - Suspended line: voltage high, current low; entered from active on link_suspended unless a repeat-flagged power frame ends in the same cycle.
`timescale 1ns/10ps

module swat_top #(
  parameter int unsigned RESYNC_CYC = swat_pkg::RESYNC_WINDOW_CYC,
  parameter int unsigned ABANDON_CYC = swat_pkg::ABANDON_CYC,
  parameter int unsigned WARM_CYC = swat_pkg::WARM_RESUME_CYC,
  parameter int unsigned CLAMP_CYC = swat_pkg::GND_CLAMP_CYC,
  parameter int unsigned DEACT_CYC = swat_pkg::DEACT_LOW_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic master_voltage_signal,
  input wire logic contact_tied_supply,
  input wire logic resume_req,
  input wire logic link_suspended,
  input wire logic power_frame_done,
  input wire logic frame_repeat_flag,
  input wire logic low_power_mode_in,
  input wire logic contact_if_active,
  input wire logic swp_check_done,
  input wire logic terminal_swp_support,
  output logic slave_current_signal,
  output logic contact_ground_oe,
  output logic sync_frame_start,
  output logic app_select,
  output logic resume_abandoned,
  output logic link_activated,
  output logic low_power_report
);

  // ==========================================================
  // Pin synchronisers
  logic s1_m_r, s1_s_r, s1_d_r;
  logic tie_m_r, tie_s_r;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s1_m_r <= 1'b0;
      s1_s_r <= 1'b0;
      s1_d_r <= 1'b0;
      tie_m_r <= 1'b0;
      tie_s_r <= 1'b0;
    end else begin
      s1_m_r <= master_voltage_signal;
      s1_s_r <= s1_m_r;
      s1_d_r <= s1_s_r;
      tie_m_r <= contact_tied_supply;
      tie_s_r <= tie_m_r;
    end
  end

  logic s1_rise, s1_fall;
  assign s1_rise = s1_s_r & ~s1_d_r;
  assign s1_fall = ~s1_s_r & s1_d_r;

  // ==========================================================
  // Line state machine
  swat_pkg::swat_state_e state_r, state_nxt;
  swat_pkg::swat_cnt_t cnt_r, cnt_nxt;
  swat_pkg::swat_cnt_t low_r, low_nxt;
  logic s2_r, s2_nxt;
  logic sync_r, sync_nxt;
  logic app_r, app_nxt;
  logic clamp_r, clamp_nxt;
  logic lpm_r, lpm_nxt;

  function automatic swat_pkg::swat_cnt_t swat_cnt_one();
    swat_cnt_one = swat_pkg::swat_cnt_t'(1);
  endfunction

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r + swat_cnt_one();
    low_nxt = s1_s_r ? '0 : low_r + swat_cnt_one();
    sync_nxt = 1'b0;
    app_nxt = 1'b0;
    clamp_nxt = clamp_r;
    lpm_nxt = low_power_mode_in;
    case (state_r)
      swat_pkg::ST_DEACT: begin
        low_nxt = '0;
        if (s1_rise) begin
          state_nxt = swat_pkg::ST_RESUME;
          cnt_nxt = '0;
          app_nxt = contact_if_active;
        end
      end
      swat_pkg::ST_SUSP: begin
        if (resume_req) begin
          state_nxt = swat_pkg::ST_RESUME;
          cnt_nxt = '0;
        end
      end
      swat_pkg::ST_PEND: begin
        if (link_suspended || cnt_r >= swat_pkg::swat_cnt_t'(RESYNC_CYC - 1)) begin
          state_nxt = swat_pkg::ST_RESUME;
          cnt_nxt = '0;
        end
      end
      swat_pkg::ST_RESUME: begin
        if (s1_fall) begin
          state_nxt = swat_pkg::ST_ACTIVE;
          sync_nxt = 1'b1;
        end else if (cnt_r >= swat_pkg::swat_cnt_t'(ABANDON_CYC - 1)) begin
          state_nxt = swat_pkg::ST_INHIBIT;
        end
      end
      swat_pkg::ST_ACTIVE: begin
        if (power_frame_done && frame_repeat_flag) begin
          state_nxt = swat_pkg::ST_PEND;
          cnt_nxt = '0;
        end else if (link_suspended) begin
          state_nxt = swat_pkg::ST_SUSP;
        end
      end
      swat_pkg::ST_INHIBIT: begin
      end
      default: begin
        state_nxt = swat_pkg::ST_DEACT;
      end
    endcase
    // Long low on the line deactivates it
    if (state_r != swat_pkg::ST_DEACT && low_r >= swat_pkg::swat_cnt_t'(DEACT_CYC - 1)) begin
      state_nxt = swat_pkg::ST_DEACT;
    end
    s2_nxt = (state_nxt == swat_pkg::ST_RESUME) && s1_s_r;
    if (swp_check_done && !tie_s_r && !terminal_swp_support) begin
      clamp_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_r <= swat_pkg::ST_DEACT;
      cnt_r <= '0;
      low_r <= '0;
      s2_r <= 1'b0;
      sync_r <= 1'b0;
      app_r <= 1'b0;
      clamp_r <= 1'b0;
      lpm_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      low_r <= low_nxt;
      s2_r <= s2_nxt;
      sync_r <= sync_nxt;
      app_r <= app_nxt;
      clamp_r <= clamp_nxt;
      lpm_r <= lpm_nxt;
    end
  end

  // ==========================================================
  // Output flops
  logic abandon_r, abandon_nxt;
  logic act_r, act_nxt;

  always_comb begin
    abandon_nxt = (state_nxt == swat_pkg::ST_INHIBIT);
    act_nxt = (state_nxt == swat_pkg::ST_ACTIVE);
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      abandon_r <= 1'b0;
      act_r <= 1'b0;
    end else begin
      abandon_r <= abandon_nxt;
      act_r <= act_nxt;
    end
  end

  assign slave_current_signal = s2_r;
  assign contact_ground_oe = clamp_r;
  assign sync_frame_start = sync_r;
  assign app_select = app_r;
  assign resume_abandoned = abandon_r;
  assign link_activated = act_r;
  assign low_power_report = lpm_r;

  // ==========================================================
  // Assertions
  sequence warm_rise_s;
    state_r == swat_pkg::ST_DEACT && s1_rise;
  endsequence

  sequence resync_req_s;
    state_r == swat_pkg::ST_ACTIVE && power_frame_done && frame_repeat_flag;
  endsequence

  a_warm_resume_start: assert property (@(posedge clock) disable iff (!rst_n)
    warm_rise_s |=> state_r == swat_pkg::ST_RESUME)
    else $error("warm resume not started");

  a_resync_window_kept: assert property (@(posedge clock) disable iff (!rst_n)
    state_r == swat_pkg::ST_PEND |-> cnt_r < swat_pkg::swat_cnt_t'(RESYNC_CYC))
    else $error("resync window exceeded");

  a_resync_enter_pend: assert property (@(posedge clock) disable iff (!rst_n)
    resync_req_s and (low_r < swat_pkg::swat_cnt_t'(DEACT_CYC - 1)) |=> state_r == swat_pkg::ST_PEND)
    else $error("repeat request not scheduled");

  a_abandon_bound: assert property (@(posedge clock) disable iff (!rst_n)
    state_r == swat_pkg::ST_RESUME |-> cnt_r < swat_pkg::swat_cnt_t'(ABANDON_CYC))
    else $error("resume held past abandon time");

  a_abandon_drops_current: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(abandon_r) |-> !slave_current_signal ##1 !slave_current_signal)
    else $error("current drawn after abandon");

  a_current_needs_high: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(slave_current_signal) |-> $past(s1_s_r))
    else $error("current raised while voltage low");

  a_clamp_on_missing: assert property (@(posedge clock) disable iff (!rst_n)
    swp_check_done && !tie_s_r && !terminal_swp_support |=> contact_ground_oe [*2])
    else $error("ground clamp not applied");

  a_app_select_pulse: assert property (@(posedge clock) disable iff (!rst_n)
    warm_rise_s ##0 contact_if_active |=> app_select ##1 !app_select)
    else $error("application select not flagged");

  a_deact_no_current: assert property (@(posedge clock) disable iff (!rst_n)
    state_r == swat_pkg::ST_DEACT && !s1_rise |=> !slave_current_signal)
    else $error("current drawn while deactivated");

  a_window_counter: assert property (@(posedge clock) disable iff (!rst_n)
    state_r == swat_pkg::ST_RESUME && $past(state_r) == swat_pkg::ST_RESUME |-> cnt_r == $past(cnt_r) + 1)
    else $error("window counter stalled");

endmodule // swat_top

// >>> dv/swat_master_model.sv
// Front-end master model driving the single-wire line pin
// Assumes the bench sets supply, answer and hold controls
`timescale 1ns/10ps
module swat_master_model #(
  parameter int unsigned RAISE_NS = 1000000
) (
  input wire logic supply_on,
  input wire logic answer_en,
  input wire logic hold_low,
  input wire logic slave_current_signal,
  output logic master_voltage_signal
);
  initial master_voltage_signal = 1'b0;
  // ==========================================================
  // Line raise
  // wait after supply, stay low when held
  always @(posedge supply_on or negedge hold_low) begin
    if (supply_on === 1'b1) begin
      #(RAISE_NS);
      if (supply_on && !hold_low) master_voltage_signal = 1'b1;
    end
  end
  always @(posedge hold_low) master_voltage_signal = 1'b0;
  // ==========================================================
  // Resume answer
  // sample current only while line high
  always @(posedge slave_current_signal) begin
    if (answer_en && master_voltage_signal) begin
      #650;
      master_voltage_signal = 1'b0;
      #90;
      if (!hold_low) master_voltage_signal = 1'b1;
    end
  end
endmodule // swat_master_model

// >>> dv/swat_top_test.sv
// Bench for the single-wire activation timing block
// Assumes the master model owns the line pin
`timescale 1ns/10ps
module swat_top_test;
  localparam int RSY = 50;
  localparam int ABN = 200;
  logic clock, rst_n, tie, pfd, rep, lpm, cia, chk, sup, supply_on, answer_en, hold_low, sus, rsm;
  logic master_voltage_signal, slave_current_signal, contact_ground_oe, sync_frame_start;
  logic app_select, resume_abandoned, link_activated, low_power_report, seen_app;
  int miscompares, check_count, n;
  swat_top #(.RESYNC_CYC(RSY), .ABANDON_CYC(ABN), .DEACT_CYC(20)) dut (.clock(clock), .rst_n(rst_n),
    .master_voltage_signal(master_voltage_signal), .contact_tied_supply(tie), .resume_req(rsm),
    .link_suspended(sus), .power_frame_done(pfd), .frame_repeat_flag(rep), .low_power_mode_in(lpm),
    .contact_if_active(cia), .swp_check_done(chk), .terminal_swp_support(sup),
    .slave_current_signal(slave_current_signal), .contact_ground_oe(contact_ground_oe),
    .sync_frame_start(sync_frame_start), .app_select(app_select), .resume_abandoned(resume_abandoned),
    .link_activated(link_activated), .low_power_report(low_power_report));
  swat_master_model master (.supply_on(supply_on), .answer_en(answer_en), .hold_low(hold_low),
    .slave_current_signal(slave_current_signal), .master_voltage_signal(master_voltage_signal));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) if (app_select === 1'b1) seen_app <= 1'b1;
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clock);
    #2;
  endtask
  task automatic wait_for(input int sel, input int lim);
    n = 0;
    while ((sel == 0 ? slave_current_signal : sel == 1 ? resume_abandoned :
            sel == 2 ? sync_frame_start : master_voltage_signal) !== 1'b1) begin
      tick(1);
      n++;
      if (n > lim) begin
        miscompares++;
        report_and_stop();
      end
    end
  endtask
  task automatic clamp_and_power();
    lpm = 1'b1;
    tick(3);
    check("power report", low_power_report, 1'b1);
    lpm = 1'b0;
    tick(3);
    check("power report", low_power_report, 1'b0);
    sup = 1'b1;
    chk = 1'b1;
    tick(1);
    chk = 1'b0;
    tick(4);
    check("ground no clamp", contact_ground_oe, 1'b0);
    sup = 1'b0;
    tie = 1'b1;
    tick(3);
    chk = 1'b1;
    tick(1);
    chk = 1'b0;
    tick(2);
    check("ground tied", contact_ground_oe, 1'b0);
    tie = 1'b0;
    tick(3);
    sup = 1'b0;
    chk = 1'b1;
    tick(1);
    chk = 1'b0;
    tick(2);
    check("ground clamp", contact_ground_oe, 1'b1);
  endtask
  task automatic cold_abandon();
    supply_on = 1'b1;
    wait_for(3, 30000);
    wait_for(0, 13000);
    check("cold resume window", n <= 12500, 1'b1);
    wait_for(1, ABN + 10);
    check("abandon window", n >= ABN - 5 && n <= ABN + 5, 1'b1);
    check("current after abandon", slave_current_signal, 1'b0);
    check("select cold", seen_app, 1'b0);
    pfd = 1'b1;
    rep = 1'b1;
    tick(1);
    pfd = 1'b0;
    tick(RSY + 10);
    check("current refused", slave_current_signal, 1'b0);
  endtask
  task automatic warm_select();
    answer_en = 1'b1;
    cia = 1'b1;
    hold_low = 1'b1;
    tick(40);
    check("deactivated current", slave_current_signal, 1'b0);
    seen_app = 1'b0;
    hold_low = 1'b0;
    wait_for(3, 30000);
    wait_for(0, 13000);
    check("warm resume window", n <= 12500, 1'b1);
    wait_for(2, 100);
    check("select warm", seen_app, 1'b1);
    tick(1);
    check("link activated", link_activated, 1'b1);
    check("abandon clear", resume_abandoned, 1'b0);
  endtask
  task automatic resync();
    pfd = 1'b1;
    rep = 1'b1;
    tick(1);
    pfd = 1'b0;
    wait_for(0, RSY + 10);
    check("resync window", n <= RSY, 1'b1);
    wait_for(2, 100);
    check("resync current", slave_current_signal, 1'b0);
    tick(1);
    check("resync sync", sync_frame_start, 1'b0);
  endtask
  task automatic suspend_resume();
    sus = 1'b1;
    tick(1);
    sus = 1'b0;
    tick(1);
    check("suspended link", link_activated, 1'b0);
    check("suspended current", slave_current_signal, 1'b0);
    rsm = 1'b1;
    tick(1);
    rsm = 1'b0;
    check("resume current", slave_current_signal, 1'b1);
    wait_for(2, 100);
    pfd = 1'b1;
    tick(1);
    pfd = 1'b0;
    tick(5);
    sus = 1'b1;
    tick(1);
    sus = 1'b0;
    check("early resync", slave_current_signal, 1'b1);
    wait_for(2, 100);
    tick(1);
    check("relinked", link_activated, 1'b1);
  endtask
  initial begin
    {rst_n, tie, pfd, rep, lpm, cia, chk, sup, supply_on, answer_en, hold_low, sus, rsm, seen_app} = '0;
    miscompares = 0;
    check_count = 0;
    tick(10);
    rst_n = 1'b1;
    tick(1);
    clamp_and_power();
    cold_abandon();
    warm_select();
    resync();
    suspend_resume();
    report_and_stop();
  end
endmodule // swat_top_test
